// file: verilog/sram_burst_cfg.svh
// constants for the burst sram command decode and its controller
// assumes: included by bare name from every design file that needs it
`ifndef SRAM_BURST_CFG_SVH
`define SRAM_BURST_CFG_SVH

// array geometry: 256k words of 36 bits, two beats side by side on the link
`define SRAM_ADDR_W 18
`define SRAM_DATA_W 36
// burst counter width and beat steps
`define BURST_CNT_W 2
`define BEAT_STEP_SINGLE 2'h1
`define BEAT_STEP_DOUBLE 2'h2
// start bits sit at the bottom of the address
`define START_LSB 0
`define START_MSB 1
// reset values of the echo clock pair
`define ECHO_RST 1'b0
`define ECHO_N_RST 1'b1
// controller: command buffer depth and read return latency in cycles
`define CMD_FIFO_DEPTH 8
`define READ_RETURN_LAT 3

`endif

// file: verilog/sram_burst_pkg.sv
// types shared by the sram command decode and its controller
// assumes: compiled before the interface and the modules
`default_nettype none
package sram_burst_pkg;

	// ============================================================
	// controller command kinds
	typedef enum logic [1:0] {CMD_WRITE, CMD_READ, CMD_ADVANCE, CMD_DESELECT} cmd_kind_t;

	// ============================================================
	// device launch state
	typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ} dev_state_t;

	// ============================================================
	// burst address: xor for interleaved, add modulo four for linear
	function automatic logic [1:0] burst_addr(input logic [1:0] start, input logic [1:0] beat,
		input logic interleaved);
		if (interleaved) begin
			burst_addr = start ^ beat;
		end else begin
			burst_addr = start + beat;
		end
	endfunction

endpackage
`default_nettype wire

// file: verilog/sram_link_if.sv
// link between the burst sram decode and the memory controller
// assumes: both ends on the same clock; no wire is ever left floating
`timescale 1ns/1ps
`default_nettype none
`include "sram_burst_cfg.svh"
interface sram_link_if #(
	parameter int ADDR_W = `SRAM_ADDR_W,
	parameter int DATA_W = `SRAM_DATA_W
);
	// function controls, address and static straps from the controller
	logic load_new_addr_n;
	logic write_read_select;
	logic double_single_select;
	logic burst_order_select;
	logic output_enable_n;
	logic [ADDR_W-1:0] address_in;
	// shared data lines, beat 1 high half, beat 0 low half
	logic [2*DATA_W-1:0] host_dq;
	logic host_dq_oe;
	logic [2*DATA_W-1:0] dev_dq;
	logic dev_dq_oe;
	logic [2*DATA_W-1:0] dq_line;
	// echo clock pair
	logic echo_clock;
	logic echo_clock_n;

	// resolved data level; an undriven line reads as zero
	assign dq_line = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : '0);

	modport device_mp (
		input load_new_addr_n, write_read_select, double_single_select,
		input burst_order_select, output_enable_n, address_in, dq_line,
		output dev_dq, dev_dq_oe, echo_clock, echo_clock_n
	);
	modport host_mp (
		output load_new_addr_n, write_read_select, double_single_select,
		output burst_order_select, output_enable_n, address_in, host_dq, host_dq_oe,
		input dq_line, echo_clock, echo_clock_n
	);
endinterface
`default_nettype wire

// file: verilog/sram_cmd_fifo.sv
// command buffer of the controller: synchronous fifo with valid/ready
// assumes: depth is a power of two; one clock, asynchronous reset
`timescale 1ns/1ps
`default_nettype none
`include "sram_burst_cfg.svh"
module sram_cmd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `CMD_FIFO_DEPTH
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// filling side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// draining side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [0:DEPTH-1];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [PW:0] count_r;
	logic [PW:0] count_nxt;
	logic push;
	logic pop;

	// ============================================================
	// handshakes and next fill level
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	assign count_nxt = count_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
	assign out_data_out = mem_r[rd_ptr_r];

	// storage needs no reset, valid flags guard it
	always_ff @(posedge core_clk_in) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data_in;
		end
	end

	// pointers wrap by natural overflow
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_r + PW'(push);
			rd_ptr_r <= rd_ptr_r + PW'(pop);
			count_r <= count_nxt;
		end
	end

	// full and empty kept as flops so the ports come straight from them
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			in_ready_out <= 1'b0;
			out_valid_out <= 1'b0;
		end else begin
			in_ready_out <= count_nxt != (PW+1)'(DEPTH);
			out_valid_out <= count_nxt != '0;
		end
	end
endmodule
`default_nettype wire

// file: verilog/sram_burst_device.sv
// command decode, burst addressing and data path of the burst sram
// assumes: controller logic runs on core_clk_in, so pins need no sync;
// both data beats of a cycle travel side by side on the link
// reset: rst_in clears the pipeline and the echo pair, never the array
// limitation: an advance with no live burst behind it stays idle,
// so the host reloads an address after any deselect or reset
//
// Functional notes
// - single write, new address, data next edge
// - double write, data both beats
// - single read, data repeated both halves
// - double read, data on both beats
// - advance repeats previous operation, ignores double
// - sampled at one edge, launched next
// - outputs tristate from power up
// - double beats use successive burst addresses
// - advance steps to next burst entry
// - four address burst, counter wraps
// - burst order strap fixed, high interleaved
// - interleaved xor, linear add modulo four
// - address registered on rising clock
// - counter loads from two low address bits
// - controller holds output enable low
// - double select low means double rate
`timescale 1ns/1ps
`default_nettype none
`include "sram_burst_cfg.svh"
module sram_burst_device #(
	parameter int ADDR_W = `SRAM_ADDR_W,
	parameter int DATA_W = `SRAM_DATA_W
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// link to the controller
	sram_link_if.device_mp link,
	// local status
	output logic burst_interleaved_out,
	output logic oe_pin_fault_out
);
	localparam int CW = `BURST_CNT_W;

	// ============================================================
	// burst step per launch: a double uses two entries, a single one
	function automatic logic [CW-1:0] beat_step(input logic dbl);
		if (dbl) begin
			beat_step = `BEAT_STEP_DOUBLE;
		end else begin
			beat_step = `BEAT_STEP_SINGLE;
		end
	endfunction

	// ============================================================
	// storage
	// whole array lives here; no reset, contents are undefined at start
	// a read never launches beside a write, so one access path suffices
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	// ============================================================
	// decode stage: what the controls sampled at the last edge asked for
	sram_burst_pkg::dev_state_t st_r;
	logic dbl_r;
	logic [ADDR_W-1:CW] base_r;
	logic [CW-1:0] start_r;
	// entries already used in the four-entry group
	logic [CW-1:0] beat_r;

	// ============================================================
	// strap and launch stage
	logic strap_done_r;
	logic order_r;
	logic [ADDR_W-1:0] addr_beat0;
	logic [ADDR_W-1:0] addr_beat1;
	logic [2*DATA_W-1:0] dq_r;
	logic dq_oe_r;
	logic echo_r;
	logic echo_n_r;
	logic oe_fault_r;
	logic launch_wr;
	logic launch_rd;

	// ============================================================
	// decode of the three function controls
	// all controls and the address are taken on the rising edge only
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_r <= sram_burst_pkg::ST_IDLE;
			dbl_r <= 1'b0;
			base_r <= '0;
			start_r <= '0;
			beat_r <= '0;
		end else if (!link.load_new_addr_n) begin
			// new address: read or write, single or double
			if (link.write_read_select) begin
				st_r <= sram_burst_pkg::ST_READ;
			end else begin
				st_r <= sram_burst_pkg::ST_WRITE;
			end
			dbl_r <= !link.double_single_select;
			base_r <= link.address_in[ADDR_W-1:CW];
			// start bits kept apart from the base, so a wrap never carries
			start_r <= link.address_in[`START_MSB:`START_LSB];
			beat_r <= '0;
		end else if (link.write_read_select) begin
			// continue: keep type and rate, skip the beats just used
			if (st_r != sram_burst_pkg::ST_IDLE) begin
				beat_r <= beat_r + beat_step(dbl_r);
			end
		end else begin
			// type dropped, so a later advance has nothing to continue
			st_r <= sram_burst_pkg::ST_IDLE;
		end
	end

	// ============================================================
	// burst order strap
	// caught once after reset release; later pin changes are ignored
	// a live order change mid-burst would scramble the beat addresses
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			strap_done_r <= 1'b0;
			order_r <= 1'b0;
		end else if (!strap_done_r) begin
			order_r <= link.burst_order_select;
			strap_done_r <= 1'b1;
		end
	end

	// ============================================================
	// beat addresses of the launch cycle
	// the counter is two bits wide, so a carry never reaches base_r
	assign addr_beat0 = {base_r, sram_burst_pkg::burst_addr(start_r, beat_r, order_r)};
	assign addr_beat1 = {base_r, sram_burst_pkg::burst_addr(start_r, beat_r + 2'h1, order_r)};

	// ============================================================
	// launch decode shared by the write, read and enable paths
	assign launch_wr = st_r == sram_burst_pkg::ST_WRITE;
	assign launch_rd = st_r == sram_burst_pkg::ST_READ;

	// ============================================================
	// write launch: data present one edge after the command edge
	// the host drives the line for exactly this launch cycle
	always_ff @(posedge core_clk_in) begin
		if (launch_wr) begin
			mem[addr_beat0] <= link.dq_line[DATA_W-1:0];
			if (dbl_r) begin
				mem[addr_beat1] <= link.dq_line[2*DATA_W-1:DATA_W];
			end
		end
	end

	// ============================================================
	// read launch and output enable
	// writes and deselects both drop the drivers at the edge that ends the launch cycle
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			dq_r <= '0;
			dq_oe_r <= 1'b0;
		end else begin
			dq_oe_r <= launch_rd;
			// dq_r keeps its last word while off; only the enable matters then
			if (launch_rd) begin
				if (dbl_r) begin
					dq_r <= {mem[addr_beat1], mem[addr_beat0]};
				end else begin
					// single: one word repeated so both output halves carry it
					dq_r <= {mem[addr_beat0], mem[addr_beat0]};
				end
			end
		end
	end

	// ============================================================
	// echo clock pair
	// free running, even while data outputs are off
	// reset values keep the pair complementary from the first edge
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			echo_r <= `ECHO_RST;
			echo_n_r <= `ECHO_N_RST;
		end else begin
			echo_r <= !echo_r;
			echo_n_r <= !echo_n_r;
		end
	end

	// ============================================================
	// output enable pin has no function; a high level is only flagged
	// sticky, so one short glitch on the pin is not lost
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			oe_fault_r <= 1'b0;
		end else if (link.output_enable_n) begin
			oe_fault_r <= 1'b1;
		end
	end

	// ============================================================
	// link and status outputs, all from flops
	// the strap is reported so the host side can confirm the order
	assign link.dev_dq = dq_r;
	assign link.dev_dq_oe = dq_oe_r;
	assign link.echo_clock = echo_r;
	assign link.echo_clock_n = echo_n_r;
	assign burst_interleaved_out = order_r;
	assign oe_pin_fault_out = oe_fault_r;
endmodule
`default_nettype wire

// file: verilog/sram_burst_host.sv
// memory controller end: buffers user commands and drives the link
// assumes: device on the same clock; read data returns three cycles
// after the command leaves the controller
`timescale 1ns/1ps
`default_nettype none
`include "sram_burst_cfg.svh"
module sram_burst_host #(
	parameter int ADDR_W = `SRAM_ADDR_W,
	parameter int DATA_W = `SRAM_DATA_W,
	parameter int DEPTH = `CMD_FIFO_DEPTH,
	parameter bit INTERLEAVED = 1'b0
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// command request
	input wire logic cmd_valid_in,
	output logic cmd_ready_out,
	input wire sram_burst_pkg::cmd_kind_t cmd_kind_in,
	input wire logic cmd_double_in,
	input wire logic [ADDR_W-1:0] cmd_addr_in,
	input wire logic [2*DATA_W-1:0] cmd_wdata_in,
	input wire logic issue_hold_in,
	// read answer
	output logic rsp_valid_out,
	output logic [2*DATA_W-1:0] rsp_data_out,
	// link to the device
	sram_link_if.host_mp link
);
	localparam int KW = $bits(sram_burst_pkg::cmd_kind_t);
	localparam int CMD_W = KW + 1 + ADDR_W + 2*DATA_W;
	localparam int LAT = `READ_RETURN_LAT;

	logic [CMD_W-1:0] head;
	logic head_valid;
	logic issue;
	sram_burst_pkg::cmd_kind_t head_kind;
	logic head_writes;
	logic head_reads;
	logic load_n_r;
	logic wr_sel_r;
	logic ds_sel_r;
	logic [ADDR_W-1:0] addr_r;
	logic last_live_r;
	logic last_rd_r;
	logic wr_next_r;
	logic [2*DATA_W-1:0] wdata_next_r;
	logic [2*DATA_W-1:0] dq_r;
	logic dq_oe_r;
	logic [LAT-1:0] rd_pipe_r;
	logic rsp_valid_r;
	logic [2*DATA_W-1:0] rsp_data_r;

	// ============================================================
	// command buffer; holding the drain lets it fill and stall the user
	sram_cmd_fifo #(.WIDTH(CMD_W), .DEPTH(DEPTH)) cmd_buf (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.in_valid_in(cmd_valid_in),
		.in_ready_out(cmd_ready_out),
		.in_data_in({cmd_kind_in, cmd_double_in, cmd_addr_in, cmd_wdata_in}),
		.out_valid_out(head_valid),
		.out_ready_in(issue),
		.out_data_out(head)
	);

	// ============================================================
	// head decode; a write right after a read waits one cycle
	// so the device drivers go off on the same edge that ours turn on
	assign head_kind = sram_burst_pkg::cmd_kind_t'(head[CMD_W-1 -: KW]);
	assign head_writes = head_kind == sram_burst_pkg::CMD_WRITE ||
		(head_kind == sram_burst_pkg::CMD_ADVANCE && last_live_r && !last_rd_r);
	assign head_reads = head_kind == sram_burst_pkg::CMD_READ ||
		(head_kind == sram_burst_pkg::CMD_ADVANCE && last_live_r && last_rd_r);
	assign issue = head_valid && !issue_hold_in && !(head_writes && rd_pipe_r[0]);

	// ============================================================
	// function controls; an empty cycle is a deselect
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			load_n_r <= 1'b1;
			wr_sel_r <= 1'b0;
			ds_sel_r <= 1'b1;
			addr_r <= '0;
			last_live_r <= 1'b0;
			last_rd_r <= 1'b0;
		end else if (issue && head_kind != sram_burst_pkg::CMD_DESELECT) begin
			load_n_r <= head_kind == sram_burst_pkg::CMD_ADVANCE;
			wr_sel_r <= head_kind != sram_burst_pkg::CMD_WRITE;
			ds_sel_r <= !head[CMD_W-1-KW];
			if (head_kind != sram_burst_pkg::CMD_ADVANCE) begin
				addr_r <= head[CMD_W-2-KW -: ADDR_W];
				last_rd_r <= head_kind == sram_burst_pkg::CMD_READ;
				last_live_r <= 1'b1;
			end
		end else begin
			load_n_r <= 1'b1;
			wr_sel_r <= 1'b0;
			last_live_r <= 1'b0;
		end
	end

	// ============================================================
	// write data goes out one cycle after its command, both beats
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_next_r <= 1'b0;
			wdata_next_r <= '0;
			dq_r <= '0;
			dq_oe_r <= 1'b0;
		end else begin
			wr_next_r <= issue && head_writes;
			wdata_next_r <= head[2*DATA_W-1:0];
			dq_oe_r <= wr_next_r;
			dq_r <= wdata_next_r;
		end
	end

	// ============================================================
	// read return: capture the line when the command has aged LAT cycles
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_pipe_r <= '0;
			rsp_valid_r <= 1'b0;
			rsp_data_r <= '0;
		end else begin
			rd_pipe_r <= {rd_pipe_r[LAT-2:0], issue && head_reads};
			rsp_valid_r <= rd_pipe_r[LAT-1];
			if (rd_pipe_r[LAT-1]) begin
				rsp_data_r <= link.dq_line;
			end
		end
	end

	// ============================================================
	// link drive; controls from flops, strap from the INTERLEAVED parameter, output enable tied low
	assign link.load_new_addr_n = load_n_r;
	assign link.write_read_select = wr_sel_r;
	assign link.double_single_select = ds_sel_r;
	assign link.address_in = addr_r;
	assign link.host_dq = dq_r;
	assign link.host_dq_oe = dq_oe_r;
	assign link.burst_order_select = INTERLEAVED;
	assign link.output_enable_n = 1'b0;
	assign rsp_valid_out = rsp_valid_r;
	assign rsp_data_out = rsp_data_r;
endmodule
`default_nettype wire

// file: testbench/sram_burst_chk.sv
// checker for the burst sram link, fed with the link signals
// assumes: instantiated beside the interface; one clock domain
`timescale 1ns/1ps
`default_nettype none
module sram_burst_chk (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// link signals
	input wire logic load_new_addr_n,
	input wire logic write_read_select,
	input wire logic output_enable_n,
	input wire logic host_dq_oe,
	input wire logic dev_dq_oe,
	input wire logic echo_clock,
	input wire logic echo_clock_n
);
	// ============================================================
	// decoded function controls
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	wire is_wr = !load_new_addr_n && !write_read_select;
	wire is_rd = !load_new_addr_n && write_read_select;
	wire is_adv = load_new_addr_n && write_read_select;
	wire is_ds = load_new_addr_n && !write_read_select;

	// ============================================================
	// properties
	property p_echo_pair; echo_clock != echo_clock_n; endproperty
	a_echo_pair: assert property (p_echo_pair) else $error("echo pair not complementary");
	// first edge after release still sees reset in the past, so it is skipped
	property p_echo_run; !$past(rst_in) |-> echo_clock != $past(echo_clock); endproperty
	a_echo_run: assert property (p_echo_run) else $error("echo clock stopped");
	property p_oe_low; !output_enable_n; endproperty
	a_oe_low: assert property (p_oe_low) else $error("output enable not low");
	property p_one_driver; !(host_dq_oe && dev_dq_oe); endproperty
	a_one_driver: assert property (p_one_driver) else $error("both ends drive data");
	// write data one edge after the command, device drivers off after launch
	property p_write; is_wr |=> host_dq_oe ##1 !dev_dq_oe; endproperty
	a_write: assert property (p_write) else $error("write launch wrong");
	property p_read; is_rd |-> ##2 dev_dq_oe; endproperty
	a_read: assert property (p_read) else $error("read data not driven");
	property p_desel; is_ds |-> ##2 !dev_dq_oe; endproperty
	a_desel: assert property (p_desel) else $error("deselect left drivers on");
	property p_adv_rd; is_rd ##1 is_adv |-> ##2 dev_dq_oe; endproperty
	a_adv_rd: assert property (p_adv_rd) else $error("advance did not continue read");
	property p_adv_idle; is_ds ##1 is_adv |-> ##2 !dev_dq_oe; endproperty
	a_adv_idle: assert property (p_adv_idle) else $error("advance after deselect drove data");

	// ============================================================
	// main scenarios reached
	c_wr_adv: cover property (is_wr ##1 is_adv);
	c_rd_rd: cover property (is_rd ##1 is_rd);
	c_ds_adv: cover property (is_ds ##1 is_adv);
endmodule
`default_nettype wire

// file: testbench/tb_ddr_burst_sram_control.sv
// bench: a linear and an interleaved link pair, driven alike, checked in order
// assumes: design and checker compiled first; single core clock
`timescale 1ns/1ps
`default_nettype none
module tb_ddr_burst_sram_control;
	// ============================================================
	// stimulus, observation and reference model
	localparam sram_burst_pkg::cmd_kind_t K_WR = sram_burst_pkg::CMD_WRITE;
	localparam sram_burst_pkg::cmd_kind_t K_RD = sram_burst_pkg::CMD_READ;
	localparam sram_burst_pkg::cmd_kind_t K_ADV = sram_burst_pkg::CMD_ADVANCE;
	localparam sram_burst_pkg::cmd_kind_t K_DS = sram_burst_pkg::CMD_DESELECT;
	logic core_clk_in;
	logic rst_in;
	logic cmd_valid;
	sram_burst_pkg::cmd_kind_t cmd_kind;
	logic cmd_double;
	logic [17:0] cmd_addr;
	logic [71:0] cmd_wdata;
	logic issue_hold;
	wire [1:0] cmd_ready, rsp_valid, strap, oe_fault, dev_oe;
	wire [71:0] rsp_data [2];
	logic [35:0] mem [logic [18:0]];
	logic [71:0] expq [2][$];
	logic [17:0] cur_a;
	logic [1:0] ptr;
	logic cur_dbl;
	logic cur_rd;
	int fail_count;
	int comparisons;

	// core clock, 4 ns period
	initial begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end

	// ============================================================
	// pair 0 linear, pair 1 interleaved; checker on pair 0 only
	for (genvar g = 0; g < 2; g++) begin : gen_pair
		sram_link_if i_sram_link_if ();
		sram_burst_host #(.INTERLEAVED(g == 1)) i_sram_burst_host (.core_clk_in(core_clk_in), .rst_in(rst_in),
			.cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready[g]), .cmd_kind_in(cmd_kind),
			.cmd_double_in(cmd_double), .cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata),
			.issue_hold_in(issue_hold), .rsp_valid_out(rsp_valid[g]), .rsp_data_out(rsp_data[g]),
			.link(i_sram_link_if));
		sram_burst_device i_sram_burst_device (.core_clk_in(core_clk_in), .rst_in(rst_in),
			.link(i_sram_link_if), .burst_interleaved_out(strap[g]), .oe_pin_fault_out(oe_fault[g]));
		assign dev_oe[g] = i_sram_link_if.dev_dq_oe;
		if (g == 0) begin : gen_chk
			sram_burst_chk i_sram_burst_chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
				.load_new_addr_n(i_sram_link_if.load_new_addr_n),
				.write_read_select(i_sram_link_if.write_read_select),
				.output_enable_n(i_sram_link_if.output_enable_n), .host_dq_oe(i_sram_link_if.host_dq_oe),
				.dev_dq_oe(i_sram_link_if.dev_dq_oe), .echo_clock(i_sram_link_if.echo_clock),
				.echo_clock_n(i_sram_link_if.echo_clock_n));
		end
	end

	// ============================================================
	// helpers
	// model address: order 1 xors the beat in, order 0 adds modulo four
	function automatic logic [18:0] key(input int o, input logic [17:0] a, input logic [1:0] b);
		key = {o[0], a[17:2], o[0] ? a[1:0] ^ b : a[1:0] + b};
	endfunction

	task automatic check_data(input string what, input logic [71:0] exp, input logic [71:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_bit(input string what, input logic exp, input logic got);
		check_data(what, {71'h0, exp}, {71'h0, got});
	endtask

	task automatic finish_test();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// offer one command, hold it until taken, then update the model
	task automatic send(input sram_burst_pkg::cmd_kind_t k, input logic dbl, input logic [17:0] a,
		input logic [71:0] w, input logic cont);
		int n;
		@(negedge core_clk_in);
		cmd_valid = 1'b1;
		cmd_kind = k;
		cmd_double = dbl;
		cmd_addr = a;
		cmd_wdata = w;
		for (n = 0; n < 64 && cmd_ready !== 2'h3; n++) begin
			@(negedge core_clk_in);
		end
		if (n == 64) begin
			fail_count++;
			finish_test();
		end else begin
			@(posedge core_clk_in);
			if (k == K_WR || k == K_RD) begin
				cur_a = a;
				ptr = 2'h0;
				cur_dbl = dbl;
				cur_rd = (k == K_RD);
			end
			// an advance with no live burst behind it changes nothing
			if (k != K_DS && (k != K_ADV || cont)) begin
				for (int o = 0; o < 2; o++) begin
					if (cur_rd) begin
						expq[o].push_back({mem[key(o, cur_a, ptr + cur_dbl)], mem[key(o, cur_a, ptr)]});
					end else begin
						mem[key(o, cur_a, ptr)] = w[35:0];
						if (cur_dbl) begin
							mem[key(o, cur_a, ptr + 2'h1)] = w[71:36];
						end
					end
				end
				ptr = ptr + (cur_dbl ? 2'h2 : 2'h1);
			end
		end
	endtask

	// stop offering, wait for all answers, then a quiet spell for strays
	task automatic drain();
		int n;
		@(negedge core_clk_in);
		cmd_valid = 1'b0;
		issue_hold = 1'b0;
		for (n = 0; n < 64 && expq[0].size() + expq[1].size() != 0; n++) begin
			@(negedge core_clk_in);
		end
		repeat (8) @(negedge core_clk_in);
		check_bit("rsp_all_seen", 1'b1, n < 64);
		if (n == 64) begin
			finish_test();
		end
	endtask

	// answers are matched in order; an answer nobody asked for is a mismatch
	always @(negedge core_clk_in) begin
		for (int o = 0; o < 2; o++) begin
			if (rsp_valid[o] === 1'b1 && expq[o].size() > 0) begin
				check_data("rsp_data", expq[o].pop_front(), rsp_data[o]);
			end else if (rsp_valid[o] !== 1'b0) begin
				check_bit("rsp_valid", 1'b0, rsp_valid[o]);
			end
		end
	end

	// ============================================================
	// main sequence
	initial begin
		rst_in = 1'b1;
		cmd_valid = 1'b0;
		cmd_kind = K_DS;
		cmd_double = 1'b0;
		cmd_addr = 18'h0;
		cmd_wdata = 72'h0;
		issue_hold = 1'b0;
		cur_rd = 1'b0;
		fail_count = 0;
		comparisons = 0;
		repeat (2) @(negedge core_clk_in);
		check_bit("dev_oe_reset", 1'b0, dev_oe[0] | dev_oe[1]);
		rst_in = 1'b0;
		repeat (2) @(negedge core_clk_in);
		check_bit("strap_linear", 1'b0, strap[0]);
		check_bit("strap_interleaved", 1'b1, strap[1]);
		check_bit("oe_fault", 1'b0, oe_fault[0] | oe_fault[1]);
		// held issue: eight commands fill the buffer, then it refuses
		issue_hold = 1'b1;
		send(K_WR, 1'b1, 18'h00013, {36'h0aaaa0001, 36'h055550000}, 1'b0);
		send(K_ADV, 1'b0, 18'h0, {36'h0aaaa0003, 36'h055550002}, 1'b1);
		for (int i = 0; i < 4; i++) begin
			send(K_RD, 1'b0, 18'(18'h00010 + i), 72'h0, 1'b0);
		end
		send(K_RD, 1'b1, 18'h00011, 72'h0, 1'b0);
		send(K_WR, 1'b0, 18'h00021, {36'h0, 36'h123456789}, 1'b0);
		@(negedge core_clk_in);
		check_bit("cmd_ready_full", 1'b0, cmd_ready[0] | cmd_ready[1]);
		drain();
		send(K_RD, 1'b0, 18'h00021, 72'h0, 1'b0);
		send(K_RD, 1'b1, 18'h00013, 72'h0, 1'b0);
		drain();
		// reads continued by advances, then read, deselect and an advance that must stay idle
		issue_hold = 1'b1;
		send(K_RD, 1'b1, 18'h00012, 72'h0, 1'b0);
		send(K_ADV, 1'b0, 18'h0, 72'h0, 1'b1);
		send(K_RD, 1'b0, 18'h00011, 72'h0, 1'b0);
		send(K_ADV, 1'b1, 18'h0, 72'h0, 1'b1);
		send(K_RD, 1'b0, 18'h00012, 72'h0, 1'b0);
		send(K_DS, 1'b1, 18'h0, 72'h0, 1'b0);
		send(K_ADV, 1'b1, 18'h0, 72'h0, 1'b0);
		drain();
		// reset in mid-run, then a write and read back
		rst_in = 1'b1;
		expq[0].delete();
		expq[1].delete();
		cur_rd = 1'b0;
		repeat (2) @(negedge core_clk_in);
		check_bit("dev_oe_reset", 1'b0, dev_oe[0] | dev_oe[1]);
		rst_in = 1'b0;
		send(K_WR, 1'b0, 18'h00005, {36'h0, 36'h0fedcba98}, 1'b0);
		send(K_RD, 1'b0, 18'h00005, 72'h0, 1'b0);
		drain();
		finish_test();
	end
endmodule
`default_nettype wire
